// File: port_reset_pkg.sv
package port_reset_pkg;
  // ---------------------------------------------------------------
  // port geometry
  // ---------------------------------------------------------------
  localparam int PORT_WIDTH = 32;
  localparam int NUM_PORTS = 3;
  localparam int NUM_PINS = PORT_WIDTH * NUM_PORTS;
  // ---------------------------------------------------------------
  // pin positions (flat index = port * 32 + bit)
  // ---------------------------------------------------------------
  localparam int PIN_BOOT_SEL0 = 0;        // port 0 bit 0
  localparam int PIN_BOOT_SEL1 = 11;       // port 0 bit 11
  localparam int PIN_SMEM_SEL0 = 4;        // port 0 bit 4
  localparam int PIN_SMEM_CLK = 5;         // port 0 bit 5
  localparam int PIN_SMEM_DIN = 6;         // port 0 bit 6
  localparam int PIN_SMEM_DOUT = 7;        // port 0 bit 7
  localparam int PIN_TEST_RTCLK = 13;      // port 0 bit 13
  localparam int PIN_TEST_DIN = 48;        // port 1 bit 16
  localparam int PIN_TEST_DOUT = 49;       // port 1 bit 17
  localparam int PIN_TEST_CLK = 50;        // port 1 bit 18
  localparam int PIN_TEST_MODE = 51;       // port 1 bit 19
  // ---------------------------------------------------------------
  // per-pin configuration codes
  // ---------------------------------------------------------------
  localparam logic [1:0] IN_FLOATING = 2'h0;
  localparam logic [1:0] IN_PULL_UP = 2'h1;
  localparam logic [1:0] IN_PULL_DOWN = 2'h2;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] BOOT_SERIAL_MEM = 2'h1;
  localparam int SYNC_STAGES = 3;
  localparam int BOOT_SAMPLE_DELAY = 2;
endpackage : port_reset_pkg

// File: returned_clock_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// multi-stage resynchroniser for the returned test clock
// ---------------------------------------------------------------
module returned_clock_sync
  import port_reset_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data
  input wire logic din,
  output logic dout
);
  logic [STAGES-1:0] stage;

  // shift chain, cleared to low while in reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage <= {stage[STAGES-2:0], din};
    end
  end

  assign dout = stage[STAGES-1];
endmodule : returned_clock_sync
`default_nettype wire

// File: pin_pad_cell.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// one pad: pull control and output driver style
// ---------------------------------------------------------------
module pin_pad_cell (
  // configuration
  input wire logic [1:0] pull_cfg,
  input wire logic open_drain,
  // driver request
  input wire logic drive_en,
  input wire logic drive_val,
  // pad side
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up,
  output logic pull_down
);
  // open-drain drives only a low, push-pull drives both levels
  always_comb begin
    pad_out = drive_val;
    pad_oe = drive_en && (!open_drain || !drive_val);
    pull_up = (pull_cfg == 2'h1);
    pull_down = (pull_cfg == 2'h2);
  end
endmodule : pin_pad_cell
`default_nettype wire

// File: port_reset_state_boot_pins.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - pins reset floating except the returned clock; test pins on debug
// - test input pins floating, accept sequences
// - test data out driven only while shifting
// - returned clock low in reset, three-stage sync
// - config regs do not select test function
// - sample two boot pins before first fetch
// - serial boot enables four serial memory pins
// - extra serial selects keep normal reset state
// - inputs floating, pull-up or pull-down
// - outputs open-drain or push-pull
module port_reset_state_boot_pins
  import port_reset_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // software pin configuration (port_config_regs)
  input wire logic [2*PINS-1:0] port_config_regs,
  input wire logic [PINS-1:0] open_drain_output,
  input wire logic [PINS-1:0] gpio_out_en,
  input wire logic [PINS-1:0] gpio_out_val,
  // pad inputs
  input wire logic [PINS-1:0] pad_in,
  // serial memory interface drive
  input wire logic serial_mem_data_out,
  input wire logic serial_mem_clock,
  input wire logic serial_mem_select0,
  // test-access shift status
  input wire logic test_shift_active,
  input wire logic test_data_out_val,
  // pad controls
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pad_pull_up,
  output logic [PINS-1:0] pad_pull_down,
  // boot and status
  output logic [1:0] boot_mode,
  output logic boot_ready,
  output logic serial_mem_data_in,
  output logic test_data_in_pin,
  output logic test_mode_select_pin,
  output logic test_clock_pin
);
  // ---------------------------------------------------------------
  // boot sampling state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_RUN = 3'h4
  } boot_state_t;

  boot_state_t state;
  logic [1:0] wait_cnt;
  logic serial_boot;
  logic rtclk_sync;
  logic [PINS-1:0] next_out;
  logic [PINS-1:0] next_oe;
  logic [PINS-1:0] next_pu;
  logic [PINS-1:0] next_pd;
  // only the returned clock pin drives while in reset
  localparam logic [PINS-1:0] OE_AT_RESET = PINS'(1) << PIN_TEST_RTCLK;

  // sampling after release, before the core is allowed to fetch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_WAIT;
      wait_cnt <= 2'h0;
      boot_mode <= CFG_RESET;
      boot_ready <= 1'b0;
    end else begin
      case (state)
        ST_WAIT: begin
          wait_cnt <= wait_cnt + 2'h1;
          if (wait_cnt == 2'(BOOT_SAMPLE_DELAY - 1)) begin
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          boot_mode <= {pad_in[PIN_BOOT_SEL1], pad_in[PIN_BOOT_SEL0]};
          state <= ST_RUN;
        end
        ST_RUN: begin
          boot_ready <= 1'b1;
        end
        default: begin
          state <= ST_WAIT;
        end
      endcase
    end
  end

  assign serial_boot = (state == ST_RUN) && (boot_mode == BOOT_SERIAL_MEM);

  // ---------------------------------------------------------------
  // returned test clock resynchroniser
  // ---------------------------------------------------------------
  returned_clock_sync #(
    .STAGES(SYNC_STAGES)
  ) u_rtclk_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(pad_in[PIN_TEST_CLK]),
    .dout(rtclk_sync)
  );

  // ---------------------------------------------------------------
  // per-pin pad cells from software configuration
  // ---------------------------------------------------------------
  logic [PINS-1:0] cell_out;
  logic [PINS-1:0] cell_oe;
  logic [PINS-1:0] cell_pu;
  logic [PINS-1:0] cell_pd;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pad
      pin_pad_cell u_cell (
        .pull_cfg(port_config_regs[2*gi +: 2]),
        .open_drain(open_drain_output[gi]),
        .drive_en(gpio_out_en[gi]),
        .drive_val(gpio_out_val[gi]),
        .pad_out(cell_out[gi]),
        .pad_oe(cell_oe[gi]),
        .pull_up(cell_pu[gi]),
        .pull_down(cell_pd[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // override of test-access and serial memory pins
  // ---------------------------------------------------------------
  always_comb begin
    next_out = cell_out;
    next_oe = cell_oe;
    next_pu = cell_pu;
    next_pd = cell_pd;
    // test pins ignore the config regs entirely
    next_oe[PIN_TEST_DIN] = 1'b0;
    next_pu[PIN_TEST_DIN] = 1'b0;
    next_pd[PIN_TEST_DIN] = 1'b0;
    next_oe[PIN_TEST_MODE] = 1'b0;
    next_pu[PIN_TEST_MODE] = 1'b0;
    next_pd[PIN_TEST_MODE] = 1'b0;
    next_oe[PIN_TEST_CLK] = 1'b0;
    next_pu[PIN_TEST_CLK] = 1'b0;
    next_pd[PIN_TEST_CLK] = 1'b0;
    next_out[PIN_TEST_DOUT] = test_data_out_val;
    next_oe[PIN_TEST_DOUT] = test_shift_active;
    next_pu[PIN_TEST_DOUT] = 1'b0;
    next_pd[PIN_TEST_DOUT] = 1'b0;
    next_out[PIN_TEST_RTCLK] = rtclk_sync;
    next_oe[PIN_TEST_RTCLK] = 1'b1;
    next_pu[PIN_TEST_RTCLK] = 1'b0;
    next_pd[PIN_TEST_RTCLK] = 1'b0;
    // extra selects on port 0 bits 12..10 keep the normal path
    if (serial_boot) begin
      next_out[PIN_SMEM_DOUT] = serial_mem_data_out;
      next_oe[PIN_SMEM_DOUT] = 1'b1;
      next_out[PIN_SMEM_CLK] = serial_mem_clock;
      next_oe[PIN_SMEM_CLK] = 1'b1;
      next_out[PIN_SMEM_SEL0] = serial_mem_select0;
      next_oe[PIN_SMEM_SEL0] = 1'b1;
      next_oe[PIN_SMEM_DIN] = 1'b0;
      next_pu[PIN_SMEM_DIN] = 1'b0;
      next_pd[PIN_SMEM_DIN] = 1'b0;
    end
  end

  // registered pad controls; floating inputs in reset except the driven returned clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe <= OE_AT_RESET;
      pad_pull_up <= '0;
      pad_pull_down <= '0;
    end else begin
      pad_out <= next_out;
      pad_oe <= next_oe;
      pad_pull_up <= next_pu;
      pad_pull_down <= next_pd;
    end
  end

  // registered pin inputs handed to the debug and serial logic
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_mem_data_in <= 1'b0;
      test_data_in_pin <= 1'b0;
      test_mode_select_pin <= 1'b0;
      test_clock_pin <= 1'b0;
    end else begin
      serial_mem_data_in <= pad_in[PIN_SMEM_DIN];
      test_data_in_pin <= pad_in[PIN_TEST_DIN];
      test_mode_select_pin <= pad_in[PIN_TEST_MODE];
      test_clock_pin <= pad_in[PIN_TEST_CLK];
    end
  end

  // ---------------------------------------------------------------
  // cycles since reset release, for the checks below
  // ---------------------------------------------------------------
  logic [2:0] run_cnt;

  // saturating count; the resynchroniser history is clean from 4 on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt <= 3'h0;
    end else if (run_cnt != 3'h7) begin
      run_cnt <= run_cnt + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // checks: reset state and test-access pins
  // ---------------------------------------------------------------
  // first edge after release still shows the reset pad state
  AST_RESET_FLOAT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(rst_n) |-> pad_oe == OE_AT_RESET && pad_pull_up == '0 && pad_pull_down == '0)
    else $error("pins not floating after reset");
  // returned clock is driven in every cycle out of reset
  AST_RTCLK_DRIVEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pad_oe[PIN_TEST_RTCLK])
    else $error("returned clock not driven");
  // only once the whole chain holds post-reset samples
  AST_RTCLK_SYNC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_cnt > 3'(SYNC_STAGES) |-> pad_out[PIN_TEST_RTCLK] == $past(pad_in[PIN_TEST_CLK], 4))
    else $error("returned clock latency wrong");
  // test data out floats while no shift is in progress
  AST_TDO_FLOAT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && !$past(test_shift_active) |-> !pad_oe[PIN_TEST_DOUT])
    else $error("test data out driven while idle");
  // test data out drives while shifting
  AST_TDO_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(test_shift_active) |-> pad_oe[PIN_TEST_DOUT])
    else $error("test data out not driven while shifting");
  // test data out carries the debug bit
  AST_TDO_VALUE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pad_out[PIN_TEST_DOUT] == $past(test_data_out_val))
    else $error("test data out value wrong");
  // test inputs never drive
  AST_TEST_IN_FLOAT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pad_oe[PIN_TEST_MODE] && !pad_oe[PIN_TEST_CLK] && !pad_oe[PIN_TEST_DIN])
    else $error("test input not floating");
  // config regs never add pulls to the test-access pins
  AST_TEST_NO_PULL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pad_pull_up[PIN_TEST_MODE:PIN_TEST_DIN] == 4'h0 && !pad_pull_up[PIN_TEST_RTCLK] &&
    pad_pull_down[PIN_TEST_MODE:PIN_TEST_DIN] == 4'h0 && !pad_pull_down[PIN_TEST_RTCLK])
    else $error("test pin pull applied");

  // ---------------------------------------------------------------
  // checks: boot sampling and serial memory pins
  // ---------------------------------------------------------------
  // mode comes from the two boot pins before the core may fetch
  AST_BOOT_SAMPLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(boot_ready) |-> boot_mode == $past({pad_in[PIN_BOOT_SEL1], pad_in[PIN_BOOT_SEL0]}, 2))
    else $error("boot mode not sampled from pins");
  // the sampled mode never moves while the core may fetch
  AST_BOOT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    boot_ready |-> $stable(boot_mode))
    else $error("boot mode moved after sampling");
  // serial boot drives clock, select and data out
  AST_SMEM_OE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(serial_boot) |-> pad_oe[PIN_SMEM_CLK] && pad_oe[PIN_SMEM_SEL0] && pad_oe[PIN_SMEM_DOUT])
    else $error("serial memory pins not enabled");
  // data in floats and the clock follows its source during serial boot
  AST_SMEM_DIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(serial_boot) |-> !pad_oe[PIN_SMEM_DIN] &&
    pad_out[PIN_SMEM_CLK] == $past(serial_mem_clock))
    else $error("serial memory data in or clock wrong");
  // outside serial boot the select pin keeps its software settings
  AST_SMEM_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && !$past(serial_boot) |->
    pad_oe[PIN_SMEM_SEL0] == $past(cell_oe[PIN_SMEM_SEL0]))
    else $error("serial select taken outside serial boot");
  // extra selects keep their software enables
  AST_EXTRA_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pad_oe[12:10] == $past(cell_oe[12:10]))
    else $error("extra selects disturbed");
  // extra selects keep their software values and pull-ups
  AST_EXTRA_SEL_OUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pad_out[12:10] == $past(cell_out[12:10]) &&
    pad_pull_up[12:10] == $past(cell_pu[12:10]))
    else $error("extra select values disturbed");

  // ---------------------------------------------------------------
  // checks: software pull and driver style
  // ---------------------------------------------------------------
  // open drain never drives a high level
  AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(open_drain_output[2]) && $past(gpio_out_val[2]) |-> !pad_oe[2])
    else $error("open drain drove high");
  // push-pull drives both levels
  AST_PUSH_PULL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(gpio_out_en[2]) && !$past(open_drain_output[2]) |->
    pad_oe[2] && pad_out[2] == $past(gpio_out_val[2]))
    else $error("push-pull output wrong");
  // pull-up code applies the pull-up
  AST_PULL_UP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(port_config_regs[3:2]) == IN_PULL_UP |-> pad_pull_up[1])
    else $error("pull-up not applied");
  // pull-down code applies only the pull-down
  AST_PULL_DOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(port_config_regs[41:40]) == IN_PULL_DOWN |-> pad_pull_down[20] && !pad_pull_up[20])
    else $error("pull-down not applied");
endmodule : port_reset_state_boot_pins
`default_nettype wire

// File: far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// debugger and serial flash beyond the pins
// ---------------------------------------------------------------
module far_side_model (
  // clock and requests
  input wire logic clk_sys,
  input wire logic frame,
  input wire logic flash_sel,
  // debugger lines
  output logic tck = 1'b0,
  output logic tms = 1'b0,
  output logic tdi = 1'b0,
  output logic shift_on = 1'b0,
  output logic tdo_bit = 1'b0,
  // flash data line
  output logic flash_out = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // debug clock runs only inside a frame and idles low
  always @(posedge clk_sys) begin
    cnt <= cnt + 4'h1;
    tck <= frame & cnt[1];
    tms <= frame & cnt[2];
    tdi <= frame ? cnt[3] : tdi;
    shift_on <= frame & cnt[3];
    tdo_bit <= cnt[0];
    flash_out <= flash_sel ? cnt[2] : ~flash_out; // released line keeps changing
  end
endmodule : far_side_model
`default_nettype wire

// File: test_port_reset_state_boot_pins.sv
`timescale 1ns/1ps
`default_nettype none
module test_port_reset_state_boot_pins;
  import port_reset_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2*NUM_PINS-1:0] cfg = {NUM_PINS{2'h1}};
  logic [NUM_PINS-1:0] od = '0, oen = '0, oval = '0, pads = '0, pin, pv;
  logic [NUM_PINS-1:0] p_out, p_oe, p_pu, p_pd;
  logic [1:0] mode;
  logic rdy, sdi, tdi_c, tms_c, tck_c, tck, tms, tdi, sh, tdo, fout;
  logic sm_do = 1'b0, sm_ck = 1'b0, sm_cs = 1'b0, frame = 1'b0, mon = 1'b0;
  logic [3:0] h = 4'h0;
  logic sp, dp;
  integer fail_count = 0, checks_done = 0;
  // far side lines land on their pads
  always_comb begin
    pin = pads;
    pin[PIN_TEST_CLK] = tck;
    pin[PIN_TEST_MODE] = tms;
    pin[PIN_TEST_DIN] = tdi;
    pin[PIN_SMEM_DIN] = fout;
  end
  port_reset_state_boot_pins dut (.clk_sys(clk_sys), .rst_n(rst_n), .port_config_regs(cfg),
    .open_drain_output(od), .gpio_out_en(oen), .gpio_out_val(oval), .pad_in(pin),
    .serial_mem_data_out(sm_do), .serial_mem_clock(sm_ck), .serial_mem_select0(sm_cs),
    .test_shift_active(sh), .test_data_out_val(tdo), .pad_out(p_out), .pad_oe(p_oe),
    .pad_pull_up(p_pu), .pad_pull_down(p_pd), .boot_mode(mode), .boot_ready(rdy),
    .serial_mem_data_in(sdi), .test_data_in_pin(tdi_c), .test_mode_select_pin(tms_c),
    .test_clock_pin(tck_c));
  far_side_model partner (.clk_sys(clk_sys), .frame(frame),
    .flash_sel(p_oe[PIN_SMEM_SEL0] & ~p_out[PIN_SMEM_SEL0]), .tck(tck), .tms(tms),
    .tdi(tdi), .shift_on(sh), .tdo_bit(tdo), .flash_out(fout));
  // ---------------------------------------------------------------
  // clock, compare and closing
  // ---------------------------------------------------------------
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // reset with chosen boot pins, then watch the boot sampling
  task automatic do_reset(input logic [1:0] b);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    pads[PIN_BOOT_SEL1] <= b[1];
    pads[PIN_BOOT_SEL0] <= b[0];
    repeat (4) @(posedge clk_sys);
    chk({1'b0, |(p_oe ^ (NUM_PINS'(1) << PIN_TEST_RTCLK)), |p_pu, |p_pd}, 4'h0);
    chk({1'b0, p_out[PIN_TEST_RTCLK], ~p_oe[PIN_TEST_RTCLK], rdy}, 4'h0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1 chk({3'h0, rdy}, 4'h0);
    repeat (6) @(posedge clk_sys);
    #1 chk({1'b0, rdy, mode}, {2'b01, b});
  endtask : do_reset
  // ---------------------------------------------------------------
  // test pin monitor: history of the debug lines
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    h <= {h[2:0], pin[PIN_TEST_CLK]};
    pv <= pin;
    sp <= sh;
    dp <= tdo;
  end
  always @(negedge clk_sys) begin
    if (mon) begin
      chk({p_out[PIN_TEST_RTCLK], p_oe[PIN_TEST_RTCLK]}, {h[3], 1'b1});
      chk({p_oe[PIN_TEST_DOUT], sp & p_out[PIN_TEST_DOUT]}, {sp, sp & dp});
      chk({tck_c, tms_c, tdi_c, p_oe[PIN_TEST_DIN]}, {pv[50], pv[51], pv[48], 1'b0});
      chk({2'h0, p_pu[PIN_TEST_CLK], p_oe[PIN_TEST_MODE]}, 4'h0);
      chk({3'h0, sdi}, {3'h0, pv[PIN_SMEM_DIN]});
    end
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(2'h1);
    @(posedge clk_sys);
    pads[PIN_BOOT_SEL0] <= 1'b0;
    sm_do <= 1'b1;
    sm_cs <= 1'b1;
    oen[12] <= 1'b1;
    oval[12] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk({2'h0, mode}, 4'h1);
    chk({p_oe[7], p_oe[5], p_oe[4], p_oe[6]}, 4'he);
    chk({p_out[7], p_out[5], p_out[4], p_pu[6]}, 4'ha);
    chk({p_pu[12], p_pu[11], p_pu[10], p_oe[12]}, 4'hf);
    chk({1'b0, p_pu[20], p_pu[PIN_TEST_DOUT], p_pu[PIN_TEST_RTCLK]}, 4'h4);
    @(posedge clk_sys);
    mon <= 1'b1;
    frame <= 1'b1;
    sm_cs <= 1'b0;
    repeat (64) @(posedge clk_sys);
    frame <= 1'b0;
    repeat (8) @(posedge clk_sys);
    mon <= 1'b0;
    // every pull code on one input pin
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys);
      cfg[41:40] <= c[1:0];
      repeat (2) @(posedge clk_sys);
      #1 chk({2'h0, p_pu[20], p_pd[20]}, {2'h0, c == 1, c == 2});
    end
    // both driver styles with both levels
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      oen[2] <= 1'b1;
      od[2] <= k[1];
      oval[2] <= k[0];
      repeat (2) @(posedge clk_sys);
      #1 chk({2'h0, p_oe[2], p_oe[2] & p_out[2]}, {2'h0, ~(k[1] & k[0]), ~k[1] & k[0]});
    end
    @(posedge clk_sys);
    oen[4] <= 1'b1;
    do_reset(2'h0);
    chk({p_oe[5], p_pu[5], p_oe[4], p_out[4]}, 4'h6);
    // non-serial mode 3 leaves the serial pins alone as well
    do_reset(2'h3);
    chk({p_oe[5], p_oe[7], p_oe[4], p_out[4]}, 4'h2);
    summarize();
  end
endmodule : test_port_reset_state_boot_pins
`default_nettype wire
